// ===== core/lsce_pkg.sv
// Shared constants for the light sensor command/enable link
package lsce_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned STARTUP_TIME_NS = 2720000;
  localparam int unsigned STARTUP_CYC = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STARTUP_W = 17;

  // Command byte layout
  localparam int unsigned CMD_SEL_BIT = 7;
  localparam int unsigned CMD_TYPE_HI = 6;
  localparam int unsigned CMD_TYPE_LO = 5;
  localparam int unsigned CMD_ADDR_HI = 4;
  localparam logic [1:0] TYPE_REPEAT = 2'h0;
  localparam logic [1:0] TYPE_AUTOINC = 2'h1;
  localparam logic [1:0] TYPE_RSVD = 2'h2;
  localparam logic [1:0] TYPE_SPECIAL = 2'h3;
  localparam logic [4:0] SF_NOP = 5'h00;
  localparam logic [4:0] SF_IRQ_CLEAR = 5'h06;

  // Function enable register
  localparam logic [4:0] FUNC_EN_ADDR = 5'h00;
  localparam logic [7:0] FUNC_EN_RESET = 8'h00;
  localparam logic [7:0] FUNC_EN_MASK = 8'h1b;
  localparam int unsigned EN_IRQ_OUT_BIT = 4;
  localparam int unsigned EN_WAIT_BIT = 3;
  localparam int unsigned EN_MEASURE_BIT = 1;
  localparam int unsigned EN_POWER_BIT = 0;

  // Link framing: one direction bit then eight data bits
  localparam logic [3:0] LINK_BITS = 4'h9;
  localparam logic [3:0] LINK_HALF = 4'h8;

  // Controller software registers
  localparam logic [4:0] HOST_CTRL_ADDR = 5'h00;
  localparam logic [4:0] HOST_STAT_ADDR = 5'h04;
  localparam logic [4:0] HOST_RXD_ADDR = 5'h08;
  localparam logic [4:0] HOST_IRQ_STAT_ADDR = 5'h0c;
  localparam logic [4:0] HOST_IRQ_MASK_ADDR = 5'h10;
  localparam int unsigned CTRL_RD_BIT = 8;
endpackage : lsce_pkg

// ===== core/lsce_link_if.sv
// Serial link between the command/enable controller and the sensor end
`timescale 1ns/1ps
`default_nettype none
interface lsce_link_if;
  logic frame_n;
  logic lclk;
  logic mosi;
  logic miso;
  modport host (output frame_n, output lclk, output mosi, input miso);
  modport dev (input frame_n, input lclk, input mosi, output miso);
endinterface : lsce_link_if
`default_nettype wire

// ===== core/lsce_dev.sv
// Sensor end: command byte decode and function enable register
//
// Notes on behaviour
// R1: Host marks command bytes with bit seven set
// R2: Bits six-five pick repeat, increment, special; ten reserved
// R3: Repeat type keeps the same register address
// R4: Increment type advances address after each byte
// R5: Low five bits: address, or special-function code
// R6: Interrupt-clear special function clears pending interrupt, self-clearing
// R7: Host writes zero to reserved enable bits
// R8: Interrupt output driven only while bit four set
// R9: Enable bit three switches the wait timer
// R10: Enable bit one switches light measurement
// R11: Enable bit zero switches the oscillator
// R12: Host waits start-up time after power-on
// R13: Device holds measurement off until start-up elapses
// R14: Reads use the latched address, advanced after each byte like writes
// R15: Data bytes store at last latched address
// R16: Pending interrupt stays until interrupt-clear command
// R17: Reserved special-function codes change nothing
`timescale 1ns/1ps
`default_nettype none
module lsce_dev
  import lsce_pkg::*;
#(
  parameter logic [STARTUP_W-1:0] STARTUP_CYCLES = STARTUP_W'(STARTUP_CYC)
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  lsce_link_if.dev link,
  input wire logic light_event_i,
  input wire logic [7:0] reg_rdata_i,
  output logic osc_on_o,
  output logic measure_go_o,
  output logic wait_timer_en_o,
  output logic light_irq_o,
  output logic irq_clear_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [4:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  function automatic logic [4:0] advance(input logic [4:0] a, input logic [1:0] t);
    advance = (t == TYPE_AUTOINC) ? 5'(a + 5'h01) : a;
  endfunction : advance

  logic [2:0] frame_sync_ff, nxt_frame_sync;
  logic [2:0] clk_sync_ff, nxt_clk_sync;
  logic [1:0] mosi_sync_ff, nxt_mosi_sync;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  logic rw_ff, nxt_rw;
  logic [7:0] rx_ff, nxt_rx;
  logic [7:0] tx_ff, nxt_tx;
  logic miso_ff, nxt_miso;
  logic [4:0] addr_ff, nxt_addr;
  logic [1:0] type_ff, nxt_type;
  logic [7:0] en_ff, nxt_en;
  logic pend_ff, nxt_pend;
  logic irq_out_ff, nxt_irq_out;
  logic clr_ff, nxt_clr;
  logic [STARTUP_W-1:0] start_cnt_ff, nxt_start_cnt;
  logic ready_ff, nxt_ready;
  logic go_ff, nxt_go;
  logic wr_ff, nxt_wr;
  logic rd_ff, nxt_rd;
  logic [4:0] reg_addr_ff, nxt_reg_addr;
  logic [7:0] wdata_ff, nxt_wdata;

  logic in_frame;
  logic rise;
  logic fall;
  logic [7:0] byte_in;
  logic [7:0] rd_val;

  always_comb begin
    // Only the second stage is looked at, plus the third stage of the link clock for edges
    nxt_frame_sync = {frame_sync_ff[1:0], link.frame_n};
    nxt_clk_sync = {clk_sync_ff[1:0], link.lclk};
    nxt_mosi_sync = {mosi_sync_ff[0], link.mosi};
    in_frame = ~frame_sync_ff[1];
    rise = in_frame & clk_sync_ff[1] & ~clk_sync_ff[2];
    fall = in_frame & ~clk_sync_ff[1] & clk_sync_ff[2];
    byte_in = {rx_ff[6:0], mosi_sync_ff[1]};
    rd_val = (addr_ff == FUNC_EN_ADDR) ? en_ff : reg_rdata_i;

    nxt_bit_cnt = bit_cnt_ff;
    nxt_rw = rw_ff;
    nxt_rx = rx_ff;
    nxt_tx = tx_ff;
    nxt_miso = miso_ff;
    nxt_addr = addr_ff;
    nxt_type = type_ff;
    nxt_en = en_ff;
    nxt_clr = 1'b0;
    nxt_wr = 1'b0;
    nxt_rd = 1'b0;
    nxt_reg_addr = reg_addr_ff;
    nxt_wdata = wdata_ff;

    if (!in_frame) begin
      nxt_bit_cnt = 4'h0;
      nxt_miso = 1'b0;
    end else if (rise && bit_cnt_ff < LINK_BITS) begin
      nxt_bit_cnt = 4'(bit_cnt_ff + 4'h1);
      if (bit_cnt_ff == 4'h0) begin
        nxt_rw = mosi_sync_ff[1];
      end else begin
        nxt_rx = byte_in;
      end
      if (bit_cnt_ff == 4'(LINK_BITS - 4'h1)) begin
        if (rw_ff) begin
          nxt_addr = advance(addr_ff, type_ff); // [R3] [R4]
        end else if (byte_in[CMD_SEL_BIT]) begin // [R1]
          case (byte_in[CMD_TYPE_HI:CMD_TYPE_LO]) // [R2]
            TYPE_REPEAT, TYPE_AUTOINC: begin
              nxt_addr = byte_in[CMD_ADDR_HI:0]; // [R5]
              nxt_type = byte_in[CMD_TYPE_HI:CMD_TYPE_LO];
            end
            TYPE_SPECIAL: begin
              // Reserved codes and no-op leave everything as is
              if (byte_in[CMD_ADDR_HI:0] == SF_IRQ_CLEAR) begin // [R5] [R17]
                nxt_clr = 1'b1; // [R6]
              end
            end
            default: begin
              // Reserved type is dropped [R2]
            end
          endcase
        end else begin
          // Data byte lands at the latched address [R15]
          if (addr_ff == FUNC_EN_ADDR) begin
            nxt_en = byte_in & FUNC_EN_MASK; // [R7]
          end else begin
            nxt_wr = 1'b1;
            nxt_reg_addr = addr_ff;
            nxt_wdata = byte_in;
          end
          nxt_addr = advance(addr_ff, type_ff); // [R3] [R4]
        end
      end
    end else if (fall && rw_ff && bit_cnt_ff != 4'h0 && bit_cnt_ff < LINK_BITS) begin
      if (bit_cnt_ff == 4'h1) begin
        // Read data taken from the latched address, as advanced after each byte [R14]
        nxt_miso = rd_val[7];
        nxt_tx = {rd_val[6:0], 1'b0};
        nxt_rd = (addr_ff != FUNC_EN_ADDR);
        nxt_reg_addr = addr_ff;
      end else begin
        nxt_miso = tx_ff[7];
        nxt_tx = {tx_ff[6:0], 1'b0};
      end
    end
    // Hold read address on the port while the external block answers
    if (in_frame && rw_ff && bit_cnt_ff == 4'h1 && !fall) begin
      nxt_reg_addr = addr_ff;
    end

    // New event wins over a clear in the same cycle [R16]
    nxt_pend = light_event_i | (pend_ff & ~clr_ff); // [R6]
    nxt_irq_out = nxt_pend & nxt_en[EN_IRQ_OUT_BIT]; // [R8]

    // Start-up hold-off restarts whenever power is dropped [R13]
    if (!nxt_en[EN_POWER_BIT]) begin
      nxt_start_cnt = '0;
      nxt_ready = 1'b0;
    end else if (start_cnt_ff >= STARTUP_CYCLES - STARTUP_W'(1)) begin
      nxt_start_cnt = start_cnt_ff;
      nxt_ready = 1'b1;
    end else begin
      nxt_start_cnt = STARTUP_W'(start_cnt_ff + STARTUP_W'(1));
      nxt_ready = 1'b0;
    end
    nxt_go = nxt_en[EN_MEASURE_BIT] & nxt_en[EN_POWER_BIT] & ready_ff; // [R10] [R13]
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      frame_sync_ff <= 3'h7;
      clk_sync_ff <= 3'h0;
      mosi_sync_ff <= 2'h0;
      bit_cnt_ff <= 4'h0;
      rw_ff <= 1'b0;
      rx_ff <= 8'h00;
      tx_ff <= 8'h00;
      miso_ff <= 1'b0;
      addr_ff <= 5'h00;
      type_ff <= TYPE_REPEAT;
      en_ff <= FUNC_EN_RESET;
      pend_ff <= 1'b0;
      irq_out_ff <= 1'b0;
      clr_ff <= 1'b0;
      start_cnt_ff <= '0;
      ready_ff <= 1'b0;
      go_ff <= 1'b0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      reg_addr_ff <= 5'h00;
      wdata_ff <= 8'h00;
    end else begin
      frame_sync_ff <= nxt_frame_sync;
      clk_sync_ff <= nxt_clk_sync;
      mosi_sync_ff <= nxt_mosi_sync;
      bit_cnt_ff <= nxt_bit_cnt;
      rw_ff <= nxt_rw;
      rx_ff <= nxt_rx;
      tx_ff <= nxt_tx;
      miso_ff <= nxt_miso;
      addr_ff <= nxt_addr;
      type_ff <= nxt_type;
      en_ff <= nxt_en;
      pend_ff <= nxt_pend;
      irq_out_ff <= nxt_irq_out;
      clr_ff <= nxt_clr;
      start_cnt_ff <= nxt_start_cnt;
      ready_ff <= nxt_ready;
      go_ff <= nxt_go;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      reg_addr_ff <= nxt_reg_addr;
      wdata_ff <= nxt_wdata;
    end
  end

  assign link.miso = miso_ff;
  assign osc_on_o = en_ff[EN_POWER_BIT]; // [R11]
  assign wait_timer_en_o = en_ff[EN_WAIT_BIT]; // [R9]
  assign measure_go_o = go_ff;
  assign light_irq_o = irq_out_ff;
  assign irq_clear_o = clr_ff;
  assign reg_wr_o = wr_ff;
  assign reg_rd_o = rd_ff;
  assign reg_addr_o = reg_addr_ff;
  assign reg_wdata_o = wdata_ff;
endmodule : lsce_dev
`default_nettype wire

// ===== core/lsce_host.sv
// Controller end: software register port driving the serial link
`timescale 1ns/1ps
`default_nettype none
module lsce_host
  import lsce_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  lsce_link_if.host link,
  input wire logic [4:0] sw_addr_i,
  input wire logic [31:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [31:0] sw_rdata_o,
  output logic irq_o
);
  typedef enum logic [1:0] {
    LSCE_IDLE = 2'b00,
    LSCE_LOW = 2'b01,
    LSCE_HIGH = 2'b10,
    LSCE_END = 2'b11
  } lsce_hstate_t;

  lsce_hstate_t st_ff, nxt_st;
  logic [3:0] div_ff, nxt_div;
  logic [3:0] bit_ff, nxt_bit;
  logic [8:0] sh_ff, nxt_sh;
  logic [7:0] rxd_ff, nxt_rxd;
  logic frame_n_ff, nxt_frame_n;
  logic lclk_ff, nxt_lclk;
  logic mosi_ff, nxt_mosi;
  logic [1:0] miso_sync_ff, nxt_miso_sync;
  logic done_ff, nxt_done;
  logic mask_ff, nxt_mask;
  logic irq_ff, nxt_irq;
  logic [31:0] rdata_ff, nxt_rdata;
  logic half_tick;

  always_comb begin
    nxt_miso_sync = {miso_sync_ff[0], link.miso};
    half_tick = (div_ff == 4'(LINK_HALF - 4'h1));
    nxt_div = half_tick ? 4'h0 : 4'(div_ff + 4'h1);
    nxt_st = st_ff;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_rxd = rxd_ff;
    nxt_frame_n = frame_n_ff;
    nxt_lclk = lclk_ff;
    nxt_mosi = mosi_ff;
    nxt_done = done_ff;
    nxt_mask = mask_ff;
    nxt_rdata = 32'h0000_0000;
    case (st_ff)
      LSCE_IDLE: begin
        nxt_div = 4'h0;
        // A write while busy is dropped; software polls the busy bit
        if (sw_wr_i && sw_addr_i == HOST_CTRL_ADDR) begin
          nxt_sh = sw_wdata_i[8:0];
          nxt_frame_n = 1'b0;
          nxt_mosi = sw_wdata_i[CTRL_RD_BIT];
          nxt_bit = 4'h0;
          nxt_st = LSCE_LOW;
        end
      end
      LSCE_LOW: begin
        if (half_tick) begin
          nxt_lclk = 1'b1;
          nxt_st = LSCE_HIGH;
          if (bit_ff != 4'h0 && sh_ff[CTRL_RD_BIT]) begin
            nxt_rxd = {rxd_ff[6:0], miso_sync_ff[1]};
          end
        end
      end
      LSCE_HIGH: begin
        if (half_tick) begin
          nxt_lclk = 1'b0;
          nxt_bit = 4'(bit_ff + 4'h1);
          if (bit_ff == 4'(LINK_BITS - 4'h1)) begin
            nxt_st = LSCE_END;
          end else begin
            // Data bits go out top bit first, the command marker first of all
            nxt_mosi = sh_ff[4'(7) - 4'(bit_ff)];
            nxt_st = LSCE_LOW;
          end
        end
      end
      LSCE_END: begin
        // Frame line stays high a half period so frames never run together
        if (half_tick && !frame_n_ff) begin
          nxt_frame_n = 1'b1;
          nxt_mosi = 1'b0;
          nxt_done = 1'b1;
        end else if (half_tick) begin
          nxt_st = LSCE_IDLE;
        end
      end
      default: begin
        nxt_st = LSCE_IDLE;
      end
    endcase
    if (sw_wr_i && sw_addr_i == HOST_IRQ_STAT_ADDR && sw_wdata_i[0]) begin
      // Completion in the same cycle keeps the bit set
      nxt_done = (st_ff == LSCE_END && half_tick && !frame_n_ff);
    end
    if (sw_wr_i && sw_addr_i == HOST_IRQ_MASK_ADDR) begin
      nxt_mask = sw_wdata_i[0];
    end
    if (sw_rd_i) begin
      case (sw_addr_i)
        HOST_STAT_ADDR: nxt_rdata = {31'h0000_0000, st_ff != LSCE_IDLE};
        HOST_RXD_ADDR: nxt_rdata = {24'h00_0000, rxd_ff};
        HOST_IRQ_STAT_ADDR: nxt_rdata = {31'h0000_0000, done_ff};
        HOST_IRQ_MASK_ADDR: nxt_rdata = {31'h0000_0000, mask_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    nxt_irq = nxt_done & nxt_mask;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_ff <= LSCE_IDLE;
      div_ff <= 4'h0;
      bit_ff <= 4'h0;
      sh_ff <= 9'h000;
      rxd_ff <= 8'h00;
      frame_n_ff <= 1'b1;
      lclk_ff <= 1'b0;
      mosi_ff <= 1'b0;
      miso_sync_ff <= 2'h0;
      done_ff <= 1'b0;
      mask_ff <= 1'b0;
      irq_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
      div_ff <= nxt_div;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      rxd_ff <= nxt_rxd;
      frame_n_ff <= nxt_frame_n;
      lclk_ff <= nxt_lclk;
      mosi_ff <= nxt_mosi;
      miso_sync_ff <= nxt_miso_sync;
      done_ff <= nxt_done;
      mask_ff <= nxt_mask;
      irq_ff <= nxt_irq;
      rdata_ff <= nxt_rdata;
    end
  end

  assign link.frame_n = frame_n_ff;
  assign link.lclk = lclk_ff;
  assign link.mosi = mosi_ff;
  assign sw_rdata_o = rdata_ff;
  assign irq_o = irq_ff;
endmodule : lsce_host
`default_nettype wire

// ===== test/lsce_chk.sv
// Link and sensor-end checks for the command/enable pair
`timescale 1ns/1ps
`default_nettype none
module lsce_chk #(
  parameter int STARTUP_CYCLES = 20
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic frame_n_i,
  input wire logic lclk_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  input wire logic light_event_i,
  input wire logic osc_on_i,
  input wire logic measure_go_i,
  input wire logic light_irq_i,
  input wire logic irq_clear_i
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // Cycles of oscillator on, restarted whenever it drops
  logic [31:0] on_cnt_ff;
  logic [31:0] nxt_on_cnt;
  always_comb begin
    nxt_on_cnt = osc_on_i ? on_cnt_ff + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_sys_i) begin
    on_cnt_ff <= rst_n_i ? nxt_on_cnt : 32'h0;
  end
  a_clear_pulse: assert property (irq_clear_i |=> !irq_clear_i)
    else $error("clear request longer than one cycle");
  a_irq_cleared: assert property (
    (irq_clear_i && !light_event_i) ##1 !light_event_i |=> !light_irq_i)
    else $error("interrupt survived a clear");
  a_go_needs_osc: assert property (measure_go_i |-> osc_on_i || $past(osc_on_i))
    else $error("measurement without oscillator");
  a_startup_hold: assert property ($rose(measure_go_i) |-> on_cnt_ff >= STARTUP_CYCLES)
    else $error("measurement started before start-up delay");
  a_lclk_half: assert property ($rose(lclk_i) |-> lclk_i [*8] ##1 !lclk_i)
    else $error("link clock high phase not eight cycles");
  a_mosi_steady: assert property (lclk_i && $past(lclk_i) |-> $stable(mosi_i))
    else $error("host data moved while link clock high");
  a_lclk_idle: assert property (frame_n_i && $past(frame_n_i) |-> !lclk_i)
    else $error("link clock active outside frame");
  // Device sees the frame end through its synchroniser, so allow that lag
  a_miso_idle: assert property (frame_n_i [*4] |-> !miso_i)
    else $error("device data active outside frame");
  c_go: cover property ($rose(measure_go_i));
  c_clear: cover property (irq_clear_i);
  c_irq_drop: cover property ($fell(light_irq_i));
  c_miso: cover property ($rose(miso_i));
endmodule : lsce_chk
`default_nettype wire

// ===== test/light_sensor_command_enable_tb.sv
// Self-checking bench: controller and sensor end joined by the link
`timescale 1ns/1ps
`default_nettype none
module light_sensor_command_enable_tb;
  import lsce_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] sw_addr = 5'h00;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic light_event = 1'b0;
  logic [31:0] sw_rdata;
  logic irq, osc_on, measure_go, wait_en, light_irq, irq_clear, reg_wr, reg_rd;
  logic [7:0] reg_rdata;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [4:0] wr_addr_seen = 5'h00;
  logic [7:0] wr_data_seen = 8'h00;
  logic [4:0] rd_addr_seen = 5'h00;
  logic [31:0] rd;
  logic [7:0] sf [3] = '{8'he5, 8'hc6, 8'he0};
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  lsce_link_if u_lsce_link_if();
  lsce_host u_lsce_host(.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link(u_lsce_link_if),
    .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd),
    .sw_rdata_o(sw_rdata), .irq_o(irq));
  lsce_dev #(.STARTUP_CYCLES(17'h64)) u_lsce_dev(.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .link(u_lsce_link_if), .light_event_i(light_event), .reg_rdata_i(reg_rdata),
    .osc_on_o(osc_on), .measure_go_o(measure_go), .wait_timer_en_o(wait_en),
    .light_irq_o(light_irq), .irq_clear_o(irq_clear), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));
  lsce_chk #(.STARTUP_CYCLES(100)) u_lsce_chk(.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .frame_n_i(u_lsce_link_if.frame_n), .lclk_i(u_lsce_link_if.lclk),
    .mosi_i(u_lsce_link_if.mosi), .miso_i(u_lsce_link_if.miso), .light_event_i(light_event),
    .osc_on_i(osc_on), .measure_go_i(measure_go), .light_irq_i(light_irq),
    .irq_clear_i(irq_clear));
  // Register file stand-in: contents tell which address was read
  assign reg_rdata = {3'h5, reg_addr};
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (reg_wr) begin
      wr_addr_seen <= reg_addr;
      wr_data_seen <= reg_wdata;
    end
    if (reg_rd) begin
      rd_addr_seen <= reg_addr;
    end
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic sw_w(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_sys_i);
    sw_wr <= 1'b0;
  endtask : sw_w
  task automatic sw_r(input logic [4:0] a);
    @(posedge clk_sys_i);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_sys_i);
    sw_rd <= 1'b0;
    #1 rd = sw_rdata;
  endtask : sw_r
  // One byte over the link; busy is polled with a bound so a stuck frame cannot hang
  task automatic xfer(input logic rdir, input logic [7:0] b);
    int n;
    n = 0;
    sw_w(HOST_CTRL_ADDR, {23'h0, rdir, b});
    do begin
      sw_r(HOST_STAT_ADDR);
      n++;
    end while (rd[0] !== 1'b0 && n < 400);
    // A frame that never ends counts as a mismatch
    chk("busy end", {31'h0, rd[0]}, 32'h0);
    if (rdir) begin
      sw_r(HOST_RXD_ADDR);
    end
  endtask : xfer
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    chk("osc after reset", osc_on, 32'h0);
    sw_r(5'h14);
    chk("unmapped", rd, 32'h0);
    xfer(1'b0, 8'h80);
    xfer(1'b0, 8'h1b);
    chk("osc on", osc_on, 32'h1);
    chk("wait on", wait_en, 32'h1);
    chk("early measure", measure_go, 32'h0);
    xfer(1'b1, 8'h00);
    chk("enable rb", rd, 32'h1b);
    xfer(1'b1, 8'h00);
    chk("enable rb again", rd, 32'h1b);
    repeat (110) @(posedge clk_sys_i);
    chk("measure", measure_go, 32'h1);
    xfer(1'b0, 8'h02);
    chk("osc off", osc_on, 32'h0);
    chk("measure off", measure_go, 32'h0);
    chk("wait off", wait_en, 32'h0);
    xfer(1'b0, 8'ha5);
    xfer(1'b0, 8'h3c);
    chk("wr addr", wr_addr_seen, 32'h05);
    chk("wr data", wr_data_seen, 32'h3c);
    xfer(1'b0, 8'h3d);
    chk("wr addr inc", wr_addr_seen, 32'h06);
    xfer(1'b0, 8'h87);
    xfer(1'b1, 8'h00);
    chk("rep rd", rd, 32'ha7);
    chk("rd addr", rd_addr_seen, 32'h07);
    xfer(1'b1, 8'h00);
    chk("rep rd again", rd, 32'ha7);
    xfer(1'b0, 8'ha9);
    xfer(1'b1, 8'h00);
    chk("inc rd", rd, 32'ha9);
    xfer(1'b1, 8'h00);
    chk("inc rd next", rd, 32'haa);
    xfer(1'b0, 8'h80);
    xfer(1'b0, 8'h11);
    @(posedge clk_sys_i);
    light_event <= 1'b1;
    @(posedge clk_sys_i);
    light_event <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk("irq out", light_irq, 32'h1);
    foreach (sf[i]) begin
      xfer(1'b0, sf[i]);
      chk("irq held", light_irq, 32'h1);
    end
    xfer(1'b0, 8'h01);
    chk("irq masked", light_irq, 32'h0);
    xfer(1'b0, 8'h11);
    chk("irq pending", light_irq, 32'h1);
    xfer(1'b0, 8'he6);
    chk("irq cleared", light_irq, 32'h0);
    sw_w(HOST_IRQ_MASK_ADDR, 32'h1);
    repeat (2) @(posedge clk_sys_i);
    chk("host irq", irq, 32'h1);
    sw_w(HOST_IRQ_STAT_ADDR, 32'h1);
    repeat (2) @(posedge clk_sys_i);
    chk("host irq clr", irq, 32'h0);
    sw_r(HOST_IRQ_STAT_ADDR);
    chk("done clr", rd, 32'h0);
    xfer(1'b0, 8'h80);
    chk("host irq again", irq, 32'h1);
    sw_w(HOST_IRQ_MASK_ADDR, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    chk("host irq mask", irq, 32'h0);
    give_verdict();
  end
endmodule : light_sensor_command_enable_tb
`default_nettype wire
